// >>> clsc_defines.vh
/*
 * Register map, field positions and reset values of the cache line
 * state controller. Assumes inclusion by clsc_top.v only.
 */
`ifndef CLSC_DEFINES_VH
`define CLSC_DEFINES_VH

`define CLSC_CTRL_OFS 8'h00
`define CLSC_RA0_OFS 8'h04
`define CLSC_RA1_OFS 8'h08
`define CLSC_STAT_OFS 8'h0c

`define CLSC_CTRL_RST 32'h00000000
`define CLSC_CTRL_WMASK 32'h00000033
`define CLSC_RA_RST 32'h00000000
`define CLSC_RA_WMASK 32'hffff8060

`define CLSC_CTRL_POL_HI 1
`define CLSC_CTRL_POL_LO 0
`define CLSC_CTRL_DKEEP 4
`define CLSC_CTRL_IKEEP 5
`define CLSC_CTRL_DFLUSH 8
`define CLSC_CTRL_IFLUSH 9

`define CLSC_RA_BASE_HI 31
`define CLSC_RA_BASE_LO 24
`define CLSC_RA_MASK_HI 23
`define CLSC_RA_MASK_LO 16
`define CLSC_RA_EN 15
`define CLSC_RA_POL_HI 6
`define CLSC_RA_POL_LO 5

`define CLSC_POL_WT 2'h0
`define CLSC_POL_CB 2'h1

`define CLSC_WAYS 4
`define CLSC_LINE_WORDS 4

`endif

// >>> clsc_top.v
/*
 * Line state control for a 4-way instruction cache and a 4-way data
 * cache sharing one fill/copyback engine, with an AHB-Lite register
 * slave. Assumes one clock, a word memory port that answers each
 * held request with a one-cycle mem_ack, and requesters that hold
 * their request until the matching ready pulse.
 */
// The register offsets and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "clsc_defines.vh"

module clsc_top #(
  parameter SB = 2
) (
  input wire clk_sys,
  input wire sys_rst,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  input wire i_req,
  input wire [31:0] i_addr,
  output wire i_ready,
  output wire [31:0] i_rdata,
  input wire d_req,
  input wire d_we,
  input wire [31:0] d_addr,
  input wire [31:0] d_wdata,
  output wire d_ready,
  output wire [31:0] d_rdata,
  input wire maint_req,
  input wire maint_data,
  input wire maint_push,
  input wire [SB-1:0] maint_set,
  input wire [1:0] maint_way,
  output wire maint_ready,
  output wire mem_req,
  output wire mem_we,
  output wire [31:0] mem_addr,
  output wire [31:0] mem_wdata,
  input wire mem_ack,
  input wire [31:0] mem_rdata
);
  localparam LB = SB + 3;
  localparam LINES = 1 << LB;
  localparam TW = 28 - SB;
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_FILL = 3'h1;
  localparam [2:0] S_DONE = 3'h2;
  localparam [2:0] S_WB = 3'h3;
  localparam [2:0] S_WT = 3'h4;

  function rmatch(input [31:0] ra, input [7:0] a);
    rmatch = ra[`CLSC_RA_EN] &&
      (((ra[`CLSC_RA_BASE_HI:`CLSC_RA_BASE_LO] ^ a) &
        ~ra[`CLSC_RA_MASK_HI:`CLSC_RA_MASK_LO]) == 8'h00);
  endfunction

  reg [31:0] ctrl_q, ra0_q, ra1_q, l_wd_q, rdata_q;
  reg ah_we_q, pbf_q, l_we_q, cm_q, dfl_q, ifl_q;
  reg [7:0] ah_ad_q;
  reg [2:0] st_q;
  reg [LINES-1:0] v_q;
  reg [LINES-1:0] m_q;
  reg [TW-1:0] tag_q [0:LINES-1];
  reg [31:0] dat_q [0:4*LINES-1];
  reg [31:0] pb_q [0:3];
  reg [27:0] pb_la_q;
  reg [1:0] rr_q, cnt_q, l_wo_q;
  reg [LB-1:0] l_line_q;
  reg [TW-1:0] l_tag_q;

  // register slave: zero wait states, every access answers OKAY
  wire ah_take = hsel && htrans[1] && hready;
  wire wr_ctrl = ah_we_q && ah_ad_q == `CLSC_CTRL_OFS;
  wire dfl_set = wr_ctrl && hwdata[`CLSC_CTRL_DFLUSH];
  wire ifl_set = wr_ctrl && hwdata[`CLSC_CTRL_IFLUSH];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ah_we_q <= 1'b0;
      ah_ad_q <= 8'h00;
      hrdata <= 32'h00000000;
      ctrl_q <= `CLSC_CTRL_RST;
      ra0_q <= `CLSC_RA_RST;
      ra1_q <= `CLSC_RA_RST;
    end else begin
      if (ah_we_q) begin
        case (ah_ad_q)
          `CLSC_CTRL_OFS: ctrl_q <= hwdata & `CLSC_CTRL_WMASK;
          `CLSC_RA0_OFS: ra0_q <= hwdata & `CLSC_RA_WMASK;
          `CLSC_RA1_OFS: ra1_q <= hwdata & `CLSC_RA_WMASK;
          default: ;
        endcase
      end
      ah_we_q <= ah_take && hwrite;
      ah_ad_q <= {haddr[7:2], 2'b00};
      if (ah_take && !hwrite) begin
        case ({haddr[7:2], 2'b00})
          `CLSC_CTRL_OFS: hrdata <= ctrl_q;
          `CLSC_RA0_OFS: hrdata <= ra0_q;
          `CLSC_RA1_OFS: hrdata <= ra1_q;
          `CLSC_STAT_OFS: hrdata <= {22'h000000, rr_q, 1'b0, ifl_q,
                                     dfl_q, pbf_q, 1'b0, st_q};
          default: hrdata <= 32'h00000000;
        endcase
      end
    end
  end

  // request selection: maintenance, then data, then instruction
  wire use_d = !maint_req && d_req;
  wire [31:0] ra = use_d ? d_addr : i_addr;
  wire [SB-1:0] rset = ra[3+SB:4];
  wire [TW-1:0] rtag = ra[31:4+SB];
  wire [1:0] pol = rmatch(ra0_q, ra[31:24]) ?
    ra0_q[`CLSC_RA_POL_HI:`CLSC_RA_POL_LO] :
    rmatch(ra1_q, ra[31:24]) ? ra1_q[`CLSC_RA_POL_HI:`CLSC_RA_POL_LO] :
    ctrl_q[`CLSC_CTRL_POL_HI:`CLSC_CTRL_POL_LO];
  wire rcb = pol == `CLSC_POL_CB;
  wire flush_pend = dfl_q || ifl_q;
  wire idle_go = st_q == S_IDLE && !flush_pend;
  wire [LB-1:0] mline = {maint_data, maint_set, maint_way};
  wire mkeep = maint_data ? ctrl_q[`CLSC_CTRL_DKEEP] :
    ctrl_q[`CLSC_CTRL_IKEEP];

  reg hit, inv_f;
  reg [1:0] hway, inv_w;
  reg [LB-1:0] li;
  integer w;
  always @* begin
    hit = 1'b0;
    hway = 2'b00;
    inv_f = 1'b0;
    inv_w = 2'b00;
    li = {LB{1'b0}};
    for (w = 3; w >= 0; w = w - 1) begin
      li = {use_d, rset, w[1:0]};
      if (v_q[li] && tag_q[li] == rtag) begin
        hit = 1'b1;
        hway = w[1:0];
      end
      if (!v_q[li]) begin
        inv_f = 1'b1;
        inv_w = w[1:0];
      end
    end
  end
  wire [1:0] vway = inv_f ? inv_w : rr_q;
  wire [LB-1:0] hline = {use_d, rset, hway};
  wire [LB-1:0] vline = {use_d, rset, vway};
  wire [SB-1:0] l_set = l_line_q[SB+1:2];

  assign maint_ready = idle_go && maint_req;
  assign d_ready = st_q == S_DONE && l_line_q[LB-1];
  assign i_ready = st_q == S_DONE && !l_line_q[LB-1];
  assign d_rdata = rdata_q;
  assign i_rdata = rdata_q;
  assign mem_req = st_q == S_FILL || st_q == S_WB || st_q == S_WT;
  assign mem_we = st_q == S_WB || st_q == S_WT;
  assign mem_addr = st_q == S_WB ? {pb_la_q, cnt_q, 2'b00} :
    st_q == S_WT ? {l_tag_q, l_set, l_wo_q, 2'b00} :
    {l_tag_q, l_set, cnt_q, 2'b00};
  assign mem_wdata = st_q == S_WB ? pb_q[cnt_q] : l_wd_q;

  integer k;
  integer j;
  always @(posedge clk_sys) begin
    if (st_q == S_FILL && mem_ack)
      dat_q[{l_line_q, cnt_q}] <= mem_rdata;
    if (st_q == S_DONE && cm_q && l_we_q)
      dat_q[{l_line_q, l_wo_q}] <= l_wd_q;
    if (st_q == S_DONE && cm_q)
      tag_q[l_line_q] <= l_tag_q;
    if (idle_go && !maint_req && use_d && d_we && hit)
      dat_q[{hline, ra[3:2]}] <= d_wdata;
  end

  // push buffer capture: data victim on a filling miss, or a pushed modified line
  always @(posedge clk_sys) begin
    if (idle_go && maint_req && maint_push && m_q[mline]) begin
      for (k = 0; k < 4; k = k + 1)
        pb_q[k] <= dat_q[{mline, k[1:0]}];
      pb_la_q <= {tag_q[mline], maint_set};
    end else if (idle_go && use_d && !hit && (!d_we || rcb)) begin
      for (k = 0; k < 4; k = k + 1)
        pb_q[k] <= dat_q[{vline, k[1:0]}];
      pb_la_q <= {tag_q[vline], rset};
    end
  end

  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= S_IDLE;
      v_q <= {LINES{1'b0}};
      m_q <= {LINES{1'b0}};
      pbf_q <= 1'b0;
      rr_q <= 2'b00;
      cnt_q <= 2'b00;
      l_line_q <= {LB{1'b0}};
      l_tag_q <= {TW{1'b0}};
      l_wo_q <= 2'b00;
      l_we_q <= 1'b0;
      l_wd_q <= 32'h00000000;
      cm_q <= 1'b0;
      rdata_q <= 32'h00000000;
      dfl_q <= 1'b0;
      ifl_q <= 1'b0;
    end else begin
      // a flush request landing on the clearing cycle is kept
      dfl_q <= (dfl_q && st_q != S_IDLE) || dfl_set;
      ifl_q <= (ifl_q && st_q != S_IDLE) || ifl_set;
      case (st_q)
        S_IDLE: begin
          if (flush_pend) begin
            for (j = 0; j < LINES; j = j + 1) begin
              if ((j >= LINES / 2) ? dfl_q : ifl_q) begin
                v_q[j] <= 1'b0;
                m_q[j] <= 1'b0;
              end
            end
          end else if (maint_req) begin
            m_q[mline] <= 1'b0;
            if (!maint_push) begin
              v_q[mline] <= 1'b0;
            end else begin
              v_q[mline] <= v_q[mline] && mkeep;
              if (m_q[mline]) begin
                pbf_q <= 1'b1;
                cnt_q <= 2'b00;
                st_q <= S_WB;
              end
            end
          end else if (use_d || i_req) begin
            l_tag_q <= rtag;
            l_wo_q <= ra[3:2];
            l_we_q <= use_d && d_we;
            l_wd_q <= d_wdata;
            cnt_q <= 2'b00;
            if (hit) begin
              l_line_q <= hline;
              if (!(use_d && d_we)) begin
                rdata_q <= dat_q[{hline, ra[3:2]}];
                cm_q <= 1'b0;
                st_q <= S_DONE;
              end else if (rcb) begin
                m_q[hline] <= 1'b1;
                cm_q <= 1'b0;
                st_q <= S_DONE;
              end else begin
                // write-through hit updates memory; modified drops to valid
                m_q[hline] <= 1'b0;
                st_q <= S_WT;
              end
            end else if (use_d && d_we && !rcb) begin
              l_line_q <= hline;
              st_q <= S_WT;
            end else begin
              l_line_q <= vline;
              if (!inv_f)
                rr_q <= rr_q + 2'b01;
              if (use_d && m_q[vline])
                pbf_q <= 1'b1;
              st_q <= S_FILL;
            end
          end
        end
        S_FILL: begin
          if (mem_ack) begin
            if (cnt_q == l_wo_q)
              rdata_q <= mem_rdata;
            cnt_q <= cnt_q + 2'b01;
            if (cnt_q == 2'b11) begin
              cm_q <= 1'b1;
              st_q <= S_DONE;
            end
          end
        end
        S_DONE: begin
          if (cm_q) begin
            v_q[l_line_q] <= 1'b1;
            m_q[l_line_q] <= l_we_q && l_line_q[LB-1];
          end
          cnt_q <= 2'b00;
          st_q <= pbf_q ? S_WB : S_IDLE;
        end
        S_WB: begin
          if (mem_ack) begin
            cnt_q <= cnt_q + 2'b01;
            if (cnt_q == 2'b11) begin
              pbf_q <= 1'b0;
              st_q <= S_IDLE;
            end
          end
        end
        S_WT: begin
          if (mem_ack) begin
            cm_q <= 1'b0;
            st_q <= S_DONE;
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end
endmodule // clsc_top

// >>> clsc_checker.sv
/* checker: port timing of the line state controller.
   assumes a bind into clsc_top and one clock domain. */
`timescale 1ns/1ps
module clsc_checker (
  input wire clk_sys,
  input wire sys_rst,
  input wire d_req,
  input wire i_req,
  input wire d_ready,
  input wire i_ready,
  input wire maint_ready,
  input wire mem_req,
  input wire mem_we,
  input wire [31:0] mem_addr,
  input wire mem_ack
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  a_dready_once: assert property (d_ready |=> !d_ready)
    else $error("d_ready too long");
  a_iready_once: assert property (i_ready |=> !i_ready)
    else $error("i_ready too long");
  a_dready_req: assert property (d_ready |-> d_req)
    else $error("d_ready without request");
  a_iready_req: assert property (i_ready |-> i_req)
    else $error("i_ready without request");
  a_mem_held: assert property (mem_req && !mem_ack |=>
    mem_req && $stable(mem_addr) && $stable(mem_we))
    else $error("memory request dropped");
  a_word_align: assert property (
    mem_req |-> mem_addr[1:0] == 2'h0)
    else $error("memory address unaligned");
  a_fill_order: assert property (
    mem_req && mem_ack && !mem_we && mem_addr[3:2] != 2'h3 |=> mem_req &&
    !mem_we && mem_addr[3:2] == $past(mem_addr[3:2]) + 2'h1)
    else $error("fill word order");
  a_fill_ready: assert property (
    mem_req && mem_ack && !mem_we && mem_addr[3:2] == 2'h3 |=>
    (d_ready || i_ready) && !mem_req)
    else $error("no ready after fill");
  a_ready_quiet: assert property (d_ready |-> !mem_req)
    else $error("ready during memory cycle");
  a_maint_quiet: assert property (
    maint_ready |-> !mem_req && !d_ready)
    else $error("maintenance taken while busy");
  c_wb: cover property (mem_req && mem_we && mem_ack);
  c_maint: cover property (maint_ready);
  c_fetch: cover property (i_ready);
  c_data: cover property (d_ready);
endmodule // clsc_checker

bind clsc_top clsc_checker u_chk (.clk_sys, .sys_rst, .d_req, .i_req,
  .d_ready, .i_ready, .maint_ready, .mem_req, .mem_we, .mem_addr, .mem_ack);

// >>> clsc_mem_model.sv
/* word memory behind the fill and copyback engine.
   assumes requests held until ack; acks after 0..3 idle cycles. */
`timescale 1ns/1ps
module clsc_mem_model (
  input wire clk_sys,
  input wire mem_req,
  input wire mem_we,
  input wire [31:0] mem_addr,
  input wire [31:0] mem_wdata,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  logic [31:0] mem [logic [31:0]];
  integer seed = 32'h7e3f8b24;
  integer wt = 0;
  function automatic logic [31:0] rd(input logic [31:0] a);
    return mem.exists(a) ? mem[a] : a ^ 32'h3c5a0000;
  endfunction
  initial begin
    mem_ack = 1'b0;
    mem_rdata = 32'h0;
  end
  always @(posedge clk_sys) begin
    mem_ack <= 1'b0;
    // data is only valid with the ack, so it toggles otherwise
    mem_rdata <= ~mem_rdata;
    if (mem_req && !mem_ack) begin
      if (wt == 0) begin
        mem_ack <= 1'b1;
        if (mem_we) mem[mem_addr] = mem_wdata;
        else mem_rdata <= rd(mem_addr);
        wt = $random(seed) & 3;
      end else wt = wt - 1;
    end
  end
endmodule // clsc_mem_model

// >>> tb_top.sv
/* bench: random data traffic over copyback and write-through regions,
   fetches, pushes and invalidates, checked against a value model.
   assumes clsc_top, clsc_mem_model and the bound checker. */
`timescale 1ns/1ps
module tb_top;
  logic clk_sys = 0, sys_rst = 1, hsel = 0, hwrite = 0;
  logic [1:0] htrans = 0, maint_set = 0, maint_way = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, i_rdata, d_rdata;
  logic hreadyout, hresp, i_ready, d_ready, maint_ready;
  logic i_req = 0, d_req = 0, d_we = 0, maint_req = 0;
  logic maint_data = 0, maint_push = 0, mem_req, mem_we, mem_ack;
  logic [31:0] i_addr = 0, d_addr = 0, d_wdata = 0;
  logic [31:0] mem_addr, mem_wdata, mem_rdata, a, v, r;
  logic [31:0] vw [logic [31:0]];
  integer num_errors = 0, checks = 0, nrd = 0, k, n;
  integer seed = 32'h7e3f8b24;
  clsc_top #(.SB(2)) i_dut (.clk_sys, .sys_rst, .hsel, .haddr, .htrans,
    .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout,
    .hresp, .hrdata, .i_req, .i_addr, .i_ready, .i_rdata, .d_req, .d_we,
    .d_addr, .d_wdata, .d_ready, .d_rdata, .maint_req, .maint_data,
    .maint_push, .maint_set, .maint_way, .maint_ready, .mem_req, .mem_we,
    .mem_addr, .mem_wdata, .mem_ack, .mem_rdata);
  clsc_mem_model i_mem (.clk_sys, .mem_req, .mem_we, .mem_addr,
    .mem_wdata, .mem_ack, .mem_rdata);
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (mem_req && mem_ack && !mem_we) nrd <= nrd + 1;
  function logic [31:0] ev(input logic [31:0] ad);
    return vw.exists(ad) ? vw[ad] : ad ^ 32'h3c5a0000;
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // ready is looked at mid-cycle so the taking edge is never raced
  task automatic hold(ref logic s);
    integer c;
    c = 0;
    do begin
      @(negedge clk_sys);
      c++;
    end while (s !== 1'b1 && c < 500);
    if (s !== 1'b1) chk(32'h0, 32'h1);
    @(posedge clk_sys);
  endtask
  task ahb(input logic w, input logic [31:0] ad, wd);
    hsel <= 1;
    htrans <= 2'h2;
    haddr <= ad;
    hwrite <= w;
    hold(hreadyout);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= wd;
    hold(hreadyout);
    v = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask
  task dacc(input logic w, input logic [31:0] ad, wd);
    k = nrd;
    d_req <= 1;
    d_we <= w;
    d_addr <= ad;
    d_wdata <= wd;
    hold(d_ready);
    d_req <= 0;
    if (w) vw[ad] = wd;
    else chk(d_rdata, ev(ad));
    // a free edge keeps the next request off the edge that drops this one
    @(posedge clk_sys);
  endtask
  task mnt(input logic dt, ps, input logic [1:0] s, wy);
    maint_req <= 1;
    maint_data <= dt;
    maint_push <= ps;
    maint_set <= s;
    maint_way <= wy;
    hold(maint_ready);
    maint_req <= 0;
    @(posedge clk_sys);
  endtask
  task fetch(input logic [31:0] ad, input logic [31:0] nr);
    k = nrd;
    i_req <= 1;
    i_addr <= ad;
    hold(i_ready);
    i_req <= 0;
    chk(i_rdata, ad ^ 32'h3c5a0000);
    chk(32'(nrd - k), nr);
    @(posedge clk_sys);
  endtask
  task close_out;
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    #(40 * 80000);
    num_errors++;
    close_out;
  end
  initial begin
    repeat (20) @(posedge clk_sys);
    sys_rst <= 0;
    @(posedge clk_sys);
    ahb(0, 32'h04, 0);
    chk(v, 32'h0);
    ahb(1, 32'h00, 32'h1);
    ahb(1, 32'h04, 32'h10008000);
    ahb(0, 32'h04, 0);
    chk(v, 32'h10008000);
    ahb(0, 32'h00, 0);
    chk(v, 32'h1);
    ahb(0, 32'h10, 0);
    chk(v, 32'h0);
    // sixteen tags per set force victims, clean and modified
    for (n = 0; n < 300; n++) begin
      a = $random(seed);
      a = {3'h0, a[0], 19'h0, a[8:6], a[5:2], 2'h0};
      v = $random(seed);
      dacc(v[1], a, $random(seed));
      if (!(v[1] && a[28])) begin
        dacc(0, a, 0);
        chk(32'(nrd - k), 32'h0);
      end
    end
    a = 32'h10001000;
    dacc(1, a, 32'h12345678);
    chk(i_mem.rd(a), 32'h12345678);
    dacc(0, a, 0);
    chk(32'(nrd - k), 32'h4);
    fetch(32'h20000040, 32'h4);
    fetch(32'h20000044, 32'h0);
    for (n = 0; n < 4; n++) mnt(0, 0, 2'h0, 2'(n));
    fetch(32'h20000044, 32'h4);
    // every data line is pushed, keep bit clear, before memory is checked
    for (n = 0; n < 16; n++) mnt(1, 1, 2'(n >> 2), 2'(n));
    dacc(0, 32'h0, 0);
    foreach (vw[x]) chk(i_mem.rd(x), vw[x]);
    dacc(0, 32'h10, 0);
    chk(32'(nrd - k), 32'h4);
    a = 32'h20;
    r = ev(a);
    dacc(1, a, ~r);
    for (n = 0; n < 4; n++) mnt(1, 0, 2'h2, 2'(n));
    vw[a] = r;
    dacc(0, a, 0);
    // with the keep bit set a push writes the line and leaves it valid
    ahb(1, 32'h00, 32'h11);
    a = 32'h30;
    r = $random(seed);
    dacc(1, a, r);
    for (n = 0; n < 4; n++) mnt(1, 1, 2'h3, 2'(n));
    dacc(0, a, 0);
    chk(32'(nrd - k), 32'h0);
    chk(i_mem.rd(a), r);
    // flush-all of both caches drops a modified line unwritten
    dacc(1, a, ~r);
    ahb(1, 32'h00, 32'h311);
    vw[a] = r;
    dacc(0, a, 0);
    chk(32'(nrd - k), 32'h4);
    fetch(32'h20000044, 32'h4);
    ahb(0, 32'h0c, 0);
    chk(v & 32'hff, 32'h0);
    close_out;
  end
endmodule // tb_top
